// [pin_irq_cfg.svh]
`ifndef PIN_IRQ_CFG_SVH
`define PIN_IRQ_CFG_SVH
// Register indexes; byte address is four times the index
`define IDX_CTRL    8'hE9
`define IDX_LF_EN   8'hEA
`define IDX_HR_EN   8'hEB
`define IDX_FLAGS   8'hEC
`define IDX_STATUS  8'hF0
`define IDX_CLEAR   8'hF1
`define IDX_IRQ_EN  8'hF2
// Control field positions
`define CTRL_PS_LSB 0
`define CTRL_PS_MSB 1
`define CTRL_T0     2
`define CTRL_T67    7
`define CTRL_T45    6
// Reset values
`define RST_BYTE    8'h00
// Synchroniser depth, in clock cycles
`define SYNC_CYCLES 2
`endif

// [pin_irq_pkg.sv]
package pin_irq_pkg;
  // One bit per detection channel
  typedef logic [7:0] chan_vec_t;
  // Port chosen for the eight channels
  typedef enum logic [1:0] {
    SEL_PORT0,
    SEL_PORT1,
    SEL_PORT2,
    SEL_PORT3
  } port_sel_t;
endpackage

// [pin_change_interrupt_unit.sv]
`timescale 1ns/100ps
`include "pin_irq_cfg.svh"

// Notes on behaviour
// - Select field routes chosen port to channels
// - Type bit: 0 level, 1 edge
// - Negative enable allows low or falling trigger
// - Positive enable allows high or rising trigger
// - Edge flag sticks until software clears
// - Level flag shows inverted input, read-only
// - Eight independent flags in one register
// - Any enabled channel event raises request
// - Pin events drive the wake request
module pin_change_interrupt_unit (
  input  wire  logic                   MCLK,
  input  wire  logic                   RST,
  input  wire  logic                   PSEL,
  input  wire  logic                   PENABLE,
  input  wire  logic                   PWRITE,
  input  wire  logic [11:0]            PADDR,
  input  wire  logic [31:0]            PWDATA,
  output logic [31:0]                  PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire  pin_irq_pkg::chan_vec_t PORT0,
  input  wire  pin_irq_pkg::chan_vec_t PORT1,
  input  wire  pin_irq_pkg::chan_vec_t PORT2,
  input  wire  pin_irq_pkg::chan_vec_t PORT3,
  output logic                         IRQ,
  output logic                         WAKE
);
  import pin_irq_pkg::*;

  // Software registers
  chan_vec_t ctrl_reg;     // Type bits and port select
  chan_vec_t lf_en_reg;    // Low/falling enables
  chan_vec_t hr_en_reg;    // High/rising enables
  chan_vec_t flags_reg;    // Channel flags
  chan_vec_t status_reg;   // Sticky interrupt status
  chan_vec_t irq_en_reg;   // Interrupt enables
  chan_vec_t flags_next;
  chan_vec_t status_next;

  // Input path
  chan_vec_t raw_sel;      // Selected port, unsynchronised
  chan_vec_t sync1_reg;    // First stage, only feeds second
  chan_vec_t sync2_reg;    // Stable sample
  chan_vec_t prev_reg;     // Previous stable sample

  // Decoded per-channel terms
  chan_vec_t chan_type;    // 1 = edge channel
  chan_vec_t rise;
  chan_vec_t fall;
  chan_vec_t edge_ev;
  chan_vec_t lvl_ev;
  chan_vec_t chan_hit;
  chan_vec_t flag_clr;
  chan_vec_t stat_clr;

  // Bus decode
  logic      setup_ph;
  logic      wr_acc;
  logic [7:0] idx;
  logic      idx_ok;

  // Spread the six type bits over eight channels
  function automatic chan_vec_t type_of(input chan_vec_t c);
    type_of = {c[`CTRL_T67], c[`CTRL_T67],
               c[`CTRL_T45], c[`CTRL_T45],
               c[5:`CTRL_T0]};
  endfunction

  // Known register index check
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == `IDX_CTRL)   || (i == `IDX_LF_EN) ||
                (i == `IDX_HR_EN)  || (i == `IDX_FLAGS) ||
                (i == `IDX_STATUS) || (i == `IDX_CLEAR) ||
                (i == `IDX_IRQ_EN);
  endfunction

  // Word index; low two address bits ignored
  assign idx      = PADDR[9:2];
  assign idx_ok   = is_mapped(idx) && (PADDR[11:10] == 2'h0);
  assign setup_ph = PSEL && !PENABLE;
  // Write lands in the access cycle with ready high
  assign wr_acc   = PSEL && PENABLE && PWRITE && PREADY;

  // Port routing
  always_comb begin
    case (port_sel_t'(ctrl_reg[`CTRL_PS_MSB:`CTRL_PS_LSB]))
      SEL_PORT0: raw_sel = PORT0;
      SEL_PORT1: raw_sel = PORT1;
      SEL_PORT2: raw_sel = PORT2;
      SEL_PORT3: raw_sel = PORT3;
      default:   raw_sel = PORT0;
    endcase
  end

  // Two-stage synchroniser plus history sample
  // Switching ports can show as one edge; software
  // should clear flags after changing the select.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync1_reg <= `RST_BYTE;
      sync2_reg <= `RST_BYTE;
      prev_reg  <= `RST_BYTE;
    end else begin
      sync1_reg <= raw_sel;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Trigger detection per channel
  always_comb begin
    chan_type = type_of(ctrl_reg);
    rise      = sync2_reg & ~prev_reg;
    fall      = ~sync2_reg & prev_reg;
    // Both enables set: either edge counts
    edge_ev   = (fall & lf_en_reg)
              | (rise & hr_en_reg);
    lvl_ev    = (~sync2_reg & lf_en_reg)
              | (sync2_reg & hr_en_reg);
    chan_hit  = (chan_type & edge_ev)
              | (~chan_type & lvl_ev);
  end

  // Software clear masks; flag bits clear on written 0
  always_comb begin
    flag_clr = `RST_BYTE;
    stat_clr = `RST_BYTE;
    if (wr_acc && idx_ok && idx == `IDX_FLAGS) begin
      flag_clr = ~PWDATA[7:0];
    end
    if (wr_acc && idx_ok && idx == `IDX_CLEAR) begin
      stat_clr = PWDATA[7:0];
    end
  end

  // Flag and status next values; set beats clear
  always_comb begin
    flags_next  = (chan_type & ((flags_reg & ~flag_clr)
                | edge_ev))
                | (~chan_type & ~sync2_reg);
    status_next = (status_reg & ~stat_clr) | chan_hit;
  end

  // Configuration registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_reg   <= `RST_BYTE;
      lf_en_reg  <= `RST_BYTE;
      hr_en_reg  <= `RST_BYTE;
      irq_en_reg <= `RST_BYTE;
    end else if (wr_acc && idx_ok) begin
      case (idx)
        `IDX_CTRL:   ctrl_reg   <= PWDATA[7:0];
        `IDX_LF_EN:  lf_en_reg  <= PWDATA[7:0];
        `IDX_HR_EN:  hr_en_reg  <= PWDATA[7:0];
        `IDX_IRQ_EN: irq_en_reg <= PWDATA[7:0];
        default:     ;
      endcase
    end
  end

  // Channel flags and sticky status
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flags_reg  <= `RST_BYTE;
      status_reg <= `RST_BYTE;
    end else begin
      flags_reg  <= flags_next;
      status_reg <= status_next;
    end
  end

  // Interrupt and wake outputs, registered in the same cycle as status
  // Wake is a clocked request; a stopped clock needs an
  // always-on clock for this block to see the pins.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      IRQ  <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      IRQ  <= |(status_next & irq_en_reg);
      WAKE <= |chan_hit;
    end
  end

  // APB answer: data and ready registered in setup
  // Zero wait states; ready drops after the access.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (setup_ph) begin
      PREADY  <= 1'b1;
      PSLVERR <= !idx_ok;
      PRDATA  <= 32'h0000_0000;
      if (!PWRITE && idx_ok) begin
        case (idx)
          `IDX_CTRL:   PRDATA[7:0] <= ctrl_reg;
          `IDX_LF_EN:  PRDATA[7:0] <= lf_en_reg;
          `IDX_HR_EN:  PRDATA[7:0] <= hr_en_reg;
          `IDX_FLAGS:  PRDATA[7:0] <= flags_next;
          `IDX_STATUS: PRDATA[7:0] <= status_next;
          `IDX_IRQ_EN: PRDATA[7:0] <= irq_en_reg;
          default:     PRDATA[7:0] <= `RST_BYTE;
        endcase
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Checks
  property p_route;
    @(posedge MCLK) disable iff (RST)
      (ctrl_reg[1:0] == 2'h2) [*3] |->
        sync2_reg == $past(PORT2, 2);
  endproperty
  a_route: assert property (p_route)
    else $error("port select did not route port 2");

  property p_fall_set;
    @(posedge MCLK) disable iff (RST)
      (chan_type[0] && lf_en_reg[0] && fall[0])
        |=> flags_reg[0];
  endproperty
  a_fall_set: assert property (p_fall_set)
    else $error("falling edge did not set flag");

  property p_rise_set;
    @(posedge MCLK) disable iff (RST)
      (chan_type[7] && hr_en_reg[7] && rise[7])
        |=> flags_reg[7];
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rising edge did not set flag");

  property p_sticky;
    @(posedge MCLK) disable iff (RST)
      (flags_reg[3] && chan_type[3] && !wr_acc)
        |=> flags_reg[3];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("edge flag dropped without clear");

  property p_level;
    @(posedge MCLK) disable iff (RST)
      !chan_type[4] |=> flags_reg[4] == !$past(sync2_reg[4]);
  endproperty
  a_level: assert property (p_level)
    else $error("level flag not inverse of input");

  property p_no_en;
    @(posedge MCLK) disable iff (RST)
      (chan_type[1] && !flags_reg[1] && !lf_en_reg[1]
        && !hr_en_reg[1]) |=> !flags_reg[1];
  endproperty
  a_no_en: assert property (p_no_en)
    else $error("disabled edge channel set its flag");

  property p_irq;
    @(posedge MCLK) disable iff (RST)
      (|(chan_hit & irq_en_reg)) |=> IRQ ##0 status_reg != 8'h00;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise request");

  // Sticky status only falls through the clear register
  property p_stat_hold;
    @(posedge MCLK) disable iff (RST)
      (status_reg[0] && !(wr_acc && idx == `IDX_CLEAR))
        |=> status_reg[0];
  endproperty
  a_stat_hold: assert property (p_stat_hold)
    else $error("status bit dropped without clear");

  property p_wake;
    @(posedge MCLK) disable iff (RST)
      (|chan_hit) |=> WAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("pin event did not raise wake");

  property p_edge_2cyc;
    @(posedge MCLK) disable iff (RST)
      (chan_type[2] && lf_en_reg[2] && $stable(lf_en_reg)
        && $stable(chan_type) && $fell(sync2_reg[2]))
        |=> flags_reg[2];
  endproperty
  a_edge_2cyc: assert property (p_edge_2cyc)
    else $error("sampled fall missed");

  c_edge: cover property (@(posedge MCLK) disable iff (RST)
    $rose(flags_reg[0]) && chan_type[0]);
  c_level: cover property (@(posedge MCLK) disable iff (RST)
    flags_reg[5] && !chan_type[5]);
  c_irq: cover property (@(posedge MCLK) disable iff (RST)
    $rose(IRQ));
  c_err: cover property (@(posedge MCLK) disable iff (RST)
    PSLVERR && PREADY);

endmodule // pin_change_interrupt_unit

// [key_pins.sv]
`timescale 1ns/100ps
// Buttons on the four ports; pull-ups keep a released line high
module key_pins (
  input  wire logic                   mclk,
  input  wire logic [7:0]             press [4],
  output pin_irq_pkg::chan_vec_t      pins  [4]
);
  import pin_irq_pkg::*;
  // A pressed key pulls its line low, changing just after the edge
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      pins[i] <= ~press[i];
    end
  end
endmodule // key_pins

// [pin_change_interrupt_unit_bench.sv]
`timescale 1ns/100ps
`include "pin_irq_cfg.svh"
`define CHK(nm, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", nm, exp, got); end end
module pin_change_interrupt_unit_bench;
  import pin_irq_pkg::*;
  logic        MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0;
  logic        PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR, IRQ, WAKE, err;
  logic [7:0]  press [4] = '{default: 8'h00}; // No key pressed
  chan_vec_t   pins [4];
  logic [31:0] rdat;
  logic [7:0]  rw_idx [4] = '{`IDX_CTRL, `IDX_LF_EN, `IDX_HR_EN,
                              `IDX_IRQ_EN};
  int          miscompares = 0, comparisons = 0;

  pin_change_interrupt_unit dut_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PORT0(pins[0]), .PORT1(pins[1]), .PORT2(pins[2]), .PORT3(pins[3]),
    .IRQ(IRQ), .WAKE(WAKE));
  key_pins keys_u (.mclk(MCLK), .press(press), .pins(pins));

  // 100 MHz system clock
  initial forever #5 MCLK = ~MCLK;

  task automatic results();
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer; the wait for PREADY is bounded
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= {24'h000000, wd};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    // Whole word taken, so the unused upper bits are checked too
    rdat = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK($sformatf("reg %h", idx), exp, rdat)
    `CHK("slverr", 1'b0, err)
  endtask

  // Covers the synchroniser plus edge compare and output stage
  task automatic settle();
    repeat (8) @(posedge MCLK);
  endtask

  initial begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    // Reset values, then read-write registers
    foreach (rw_idx[i]) rd(rw_idx[i], 8'h00);
    rd(`IDX_FLAGS, 8'h00);
    rd(`IDX_STATUS, 8'h00);
    foreach (rw_idx[i]) apb(1'b1, rw_idx[i], 8'hA5);
    foreach (rw_idx[i]) rd(rw_idx[i], 8'hA5);
    foreach (rw_idx[i]) apb(1'b1, rw_idx[i], 8'h00);
    // Unmapped place is refused both ways
    apb(1'b0, 8'h10, 8'h00);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 8'h00, rdat)
    apb(1'b1, 8'h10, 8'hFF);
    `CHK("slverr", 1'b1, err)
    rd(`IDX_CLEAR, 8'h00);
    // One key per port; level flags show the chosen port inverted
    for (int p = 0; p < 4; p++) press[p] <= 8'h01 << p;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, `IDX_CTRL, 8'(p));
      settle();
      rd(`IDX_FLAGS, 8'h01 << p);
      apb(1'b1, `IDX_FLAGS, 8'h00);
      rd(`IDX_FLAGS, 8'h01 << p);
    end
    // Spurious events from earlier setup are dropped here
    apb(1'b1, `IDX_CLEAR, 8'hFF);
    rd(`IDX_STATUS, 8'h00);
    // Level triggers on port 3
    apb(1'b1, `IDX_LF_EN, 8'h08);
    apb(1'b1, `IDX_IRQ_EN, 8'h08);
    settle();
    rd(`IDX_STATUS, 8'h08);
    `CHK("irq", 1'b1, IRQ)
    `CHK("wake", 1'b1, WAKE)
    apb(1'b1, `IDX_HR_EN, 8'hF7);
    settle();
    rd(`IDX_STATUS, 8'hFF);
    apb(1'b1, `IDX_IRQ_EN, 8'h00);
    settle();
    `CHK("irq masked", 1'b0, IRQ)
    apb(1'b1, `IDX_LF_EN, 8'h00);
    apb(1'b1, `IDX_HR_EN, 8'h00);
    apb(1'b1, `IDX_CLEAR, 8'hFF);
    settle();
    rd(`IDX_STATUS, 8'h00);
    `CHK("wake", 1'b0, WAKE)
    // Edge mode on port 0; channel 0 takes both edges
    for (int p = 0; p < 4; p++) press[p] <= 8'h00;
    apb(1'b1, `IDX_CTRL, 8'hFC);
    apb(1'b1, `IDX_LF_EN, 8'h0F);
    apb(1'b1, `IDX_HR_EN, 8'hF1);
    settle();
    apb(1'b1, `IDX_FLAGS, 8'h00);
    apb(1'b1, `IDX_CLEAR, 8'hFF);
    apb(1'b1, `IDX_IRQ_EN, 8'h01);
    press[0] <= 8'hFF;
    settle();
    rd(`IDX_FLAGS, 8'h0F);
    rd(`IDX_STATUS, 8'h0F);
    `CHK("irq", 1'b1, IRQ)
    apb(1'b1, `IDX_FLAGS, 8'hF0);
    rd(`IDX_FLAGS, 8'h00);
    press[0] <= 8'h00;
    settle();
    rd(`IDX_FLAGS, 8'hF1);
    apb(1'b1, `IDX_CLEAR, 8'hFF);
    rd(`IDX_STATUS, 8'h00);
    settle();
    `CHK("irq", 1'b0, IRQ)
    results();
  end
endmodule // pin_change_interrupt_unit_bench
